/* rtl/tpic_ctrl.sv */
// Timer and pin interrupt controller with its 8-bit timer/event counter.
// Assumes one pclk domain, a core that pulses instr_end at each
// instruction boundary and pushes push_pc when irq_take pulses.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tpic_ctrl #(
    parameter int PC_W = 11
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire tpic_pkg::tpic_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  instr_end,
    input  wire logic                  ret_exec,
    input  wire logic                  return_from_irq_instr_exec,
    input  wire logic                  stack_full,
    input  wire logic                  sleeping,
    input  wire logic [PC_W-1:0]       next_pc,
    input  wire logic                  pin_irq_in,
    input  wire logic                  tmr_pin_in,
    output logic                       irq_take,
    output logic [PC_W-1:0]            irq_vector,
    output logic [PC_W-1:0]            push_pc,
    output logic                       pop_req,
    output logic                       wake
);
    import tpic_pkg::*;

    logic [7:0]      icr_reg;
    logic [7:0]      tctl_reg;
    logic [7:0]      preload_reg;
    logic [7:0]      cnt_reg;
    logic [6:0]      psc_reg;
    logic [2:0]      pin_sync_reg;
    logic [2:0]      tmr_sync_reg;
    logic            pin_lvl_reg;
    logic            tmr_lvl_reg;
    logic            pw_started_reg;
    logic            woke_reg;
    logic            src_tmr_reg;
    logic [1:0]      dly_reg;
    tpic_state_t     state_reg;
    logic [31:0]     prdata_reg;
    logic            take_reg;
    logic [PC_W-1:0] vec_reg;
    logic [PC_W-1:0] push_reg;
    logic            pop_reg;
    logic            wake_reg;

    // APB decode
    wire logic acc     = apb_req.psel && apb_req.penable;
    wire logic setup   = apb_req.psel && !apb_req.penable;
    wire logic hit_icr = (apb_req.paddr == OFF_ICR);
    wire logic hit_tc  = (apb_req.paddr == OFF_TCTL);
    wire logic hit_pl  = (apb_req.paddr == OFF_PRELOAD);
    wire logic hit     = hit_icr || hit_tc || hit_pl;
    wire logic wr      = acc && apb_req.pwrite;
    wire logic wr_icr  = wr && hit_icr;
    wire logic wr_tc   = wr && hit_tc;
    wire logic wr_pl   = wr && hit_pl;
    wire logic [7:0] wdat = apb_req.pwdata[7:0];

    // Counter clock is held off during any counter or preload access
    wire logic inhibit = apb_req.psel && hit_pl;

    // Synchronised pin levels: accept once stages two and three agree
    wire logic pin_lvl_next = (pin_sync_reg[1] == pin_sync_reg[2])
                              ? pin_sync_reg[2] : pin_lvl_reg;
    wire logic tmr_lvl_next = (tmr_sync_reg[1] == tmr_sync_reg[2])
                              ? tmr_sync_reg[2] : tmr_lvl_reg;
    wire logic pin_rise = pin_lvl_next && !pin_lvl_reg;
    wire logic tmr_rise = tmr_lvl_next && !tmr_lvl_reg;
    wire logic tmr_fall = !tmr_lvl_next && tmr_lvl_reg;

    // Timer control fields
    wire logic [1:0] mode   = tctl_reg[TC_MODE_LSB +: 2];
    wire logic       run    = tctl_reg[TC_RUN];
    wire logic       edge_s = tctl_reg[TC_EDGE];
    wire logic [2:0] psc    = tctl_reg[TC_PSC_LSB +: 3];

    // Prescaled tick from the free running divider
    wire logic [6:0] psc_mask = 7'((8'h01 << psc) - 8'h01);
    wire logic       tick     = ((psc_reg & psc_mask) == psc_mask);

    // Event edge and pulse level as chosen by the edge select bit
    wire logic ev_edge  = edge_s ? tmr_fall : tmr_rise;
    wire logic pw_act   = edge_s ? tmr_lvl_reg : !tmr_lvl_reg;
    wire logic pw_end   = edge_s ? tmr_fall : tmr_rise;

    // Count source per mode; event mode counts pin edges directly, pulse mode counts ticks while the pin is active
    wire logic cnt_src = (mode == MODE_TIMER) ? tick :
                         (mode == MODE_EVENT) ? ev_edge :
                         (mode == MODE_PULSE) ? (tick && pw_act) : 1'b0;
    // Counting ignores sleep so events keep counting
    wire logic step = run && cnt_src && !inhibit;
    wire logic ovf  = step && (cnt_reg == 8'hff);

    // Pulse measure ends when the pin returns to its rest level
    wire logic pw_stop = run && (mode == MODE_PULSE) && pw_started_reg && pw_end;

    // Interrupt control fields
    wire logic gie = icr_reg[ICR_GIE];
    wire logic pie = icr_reg[ICR_PIE];
    wire logic tie = icr_reg[ICR_TIE];
    wire logic pif = icr_reg[ICR_PIF];
    wire logic tif = icr_reg[ICR_TIF];

    // Requests that may be taken now
    wire logic pin_ok = gie && pie && pif && !stack_full;
    wire logic tmr_ok = gie && tie && tif && !stack_full;
    wire logic any_ok = pin_ok || tmr_ok;
    wire logic take_now = (state_reg == ST_ENTER) && any_ok;
    wire logic take_tmr = take_now && !pin_ok;

    // Request flags: hardware set beats software or service clear
    wire logic pif_sw   = wr_icr ? wdat[ICR_PIF] : pif;
    wire logic tif_sw   = wr_icr ? wdat[ICR_TIF] : tif;
    wire logic pif_next = pin_rise || (pif_sw && !(take_now && !take_tmr));
    wire logic tif_next = ovf || (tif_sw && !take_tmr);

    // Global enable: entry clears, return from interrupt sets
    wire logic gie_sw   = wr_icr ? wdat[ICR_GIE] : gie;
    wire logic gie_next = take_now ? 1'b0 : (return_from_irq_instr_exec ? 1'b1 : gie_sw);

    wire logic [7:0] icr_next = {2'b00, tif_next, pif_next, 1'b0,
                                 wr_icr ? wdat[ICR_TIE] : tie,
                                 wr_icr ? wdat[ICR_PIE] : pie,
                                 gie_next};

    // Wake on any flag rising; an overflow wakes through the timer flag,
    // so a flag that software set before sleep keeps the device asleep
    wire logic wake_next = (pif_next && !pif)
                           || (tif_next && !tif);

    // Timer control: software write, or pulse end clears run
    wire logic [7:0] tctl_next = wr_tc ? wdat :
                                 (pw_stop ? (tctl_reg & ~(8'h01 << TC_RUN)) : tctl_reg);

    // Counter: reload on overflow, preload write loads a stopped counter
    wire logic [7:0] cnt_next = ovf ? preload_reg :
                                step ? 8'(cnt_reg + 8'h01) :
                                (wr_pl && !run) ? wdat : cnt_reg;

    // Read mux
    wire logic [7:0] rd_byte = hit_icr ? (icr_reg & ICR_IMPL_MASK) :
                               hit_tc  ? tctl_reg :
                               hit_pl  ? cnt_reg : 8'h00;

    // Vectors widened to the program counter
    wire logic [PC_W-1:0] vec_pin = PC_W'(VEC_PIN);
    wire logic [PC_W-1:0] vec_tmr = PC_W'(VEC_TMR);

    // Service sequencer next state
    tpic_state_t state_next;
    logic [1:0]  dly_next;
    always_comb
    begin
        state_next = state_reg;
        dly_next   = dly_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (instr_end && any_ok)
                begin
                    state_next = ST_WAIT;
                    dly_next   = woke_reg ? DLY_WAKE : DLY_RUN;
                end
            end
            ST_WAIT:
            begin
                if (instr_end)
                begin
                    dly_next = dly_reg - 2'd1;
                    if (dly_reg == 2'd1)
                    begin
                        state_next = ST_ENTER;
                    end
                end
            end
            ST_ENTER:
            begin
                // A full stack or cleared enable holds here or drops back
                if (take_now || !(pif || tif))
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Input synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync_reg <= 3'b000;
            tmr_sync_reg <= 3'b000;
            pin_lvl_reg  <= 1'b0;
            tmr_lvl_reg  <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], pin_irq_in};
            tmr_sync_reg <= {tmr_sync_reg[1:0], tmr_pin_in};
            pin_lvl_reg  <= pin_lvl_next;
            tmr_lvl_reg  <= tmr_lvl_next;
        end
    end

    // Registers and timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            icr_reg        <= ICR_RESET;
            tctl_reg       <= TC_RESET;
            preload_reg    <= PRELOAD_RESET;
            cnt_reg        <= PRELOAD_RESET;
            psc_reg        <= 7'h00;
            pw_started_reg <= 1'b0;
        end
        else
        begin
            icr_reg     <= icr_next;
            tctl_reg    <= tctl_next;
            preload_reg <= wr_pl ? wdat : preload_reg;
            cnt_reg     <= cnt_next;
            psc_reg     <= 7'(psc_reg + 7'h01);
            pw_started_reg <= run && (mode == MODE_PULSE) && !pw_stop
                              && (pw_started_reg || pw_act);
        end
    end

    // Service sequencer and core strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg   <= ST_IDLE;
            dly_reg     <= 2'd0;
            woke_reg    <= 1'b0;
            src_tmr_reg <= 1'b0;
            take_reg    <= 1'b0;
            vec_reg     <= '0;
            push_reg    <= '0;
            pop_reg     <= 1'b0;
            wake_reg    <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            dly_reg     <= dly_next;
            woke_reg    <= take_now ? 1'b0 : (woke_reg || (wake_next && sleeping));
            src_tmr_reg <= take_now ? take_tmr : src_tmr_reg;
            take_reg    <= take_now;
            vec_reg     <= take_now ? (take_tmr ? vec_tmr : vec_pin) : vec_reg;
            push_reg    <= take_now ? next_pc : push_reg;
            pop_reg     <= return_from_irq_instr_exec || ret_exec;
            wake_reg    <= wake_next;
        end
    end

    // Read data is captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (setup && !apb_req.pwrite)
        begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Outputs
    assign prdata     = prdata_reg;
    assign pready     = 1'b1;
    assign pslverr    = acc && !hit;
    assign irq_take   = take_reg;
    assign irq_vector = vec_reg;
    assign push_pc    = push_reg;
    assign pop_req    = pop_reg;
    assign wake       = wake_reg;

    // Checks
    property p_ovf_flag;
        @(posedge pclk) disable iff (!presetn)
        ovf |=> icr_reg[ICR_TIF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow lost flag");

    property p_sleep_wake;
        @(posedge pclk) disable iff (!presetn)
        (ovf && sleeping && !tif) |=> wake;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on overflow");

    property p_unimpl;
        @(posedge pclk) disable iff (!presetn)
        (setup && !apb_req.pwrite && hit_icr) |=> (prdata[7:6] == 2'b00 && !prdata[3]);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");

    property p_gie_block;
        @(posedge pclk) disable iff (!presetn)
        !icr_reg[ICR_GIE] |=> !irq_take;
    endproperty
    a_gie_block: assert property (p_gie_block) else $error("take with gie low");

    property p_take_clears;
        @(posedge pclk) disable iff (!presetn)
        take_now |=> !icr_reg[ICR_GIE] && irq_take;
    endproperty
    a_take_clears: assert property (p_take_clears) else $error("gie kept on entry");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        irq_take |-> (irq_vector == (src_tmr_reg ? vec_tmr : vec_pin));
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_full;
        @(posedge pclk) disable iff (!presetn)
        stack_full |=> !irq_take;
    endproperty
    a_full: assert property (p_full) else $error("take on full stack");

    property p_return_from_irq_instr;
        @(posedge pclk) disable iff (!presetn)
        (return_from_irq_instr_exec && !take_now) |=> icr_reg[ICR_GIE] && pop_req;
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return_from_irq_instr left gie low");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        (take_now && pin_ok) |=> (irq_vector == vec_pin);
    endproperty
    a_prio: assert property (p_prio) else $error("timer beat pin");

    property p_inhibit;
        @(posedge pclk) disable iff (!presetn)
        (inhibit && !wr_pl) |=> $stable(cnt_reg);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("count during access");

    property p_wake_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(icr_reg[ICR_PIF]) |-> $past(wake_next);
    endproperty
    a_wake_rise: assert property (p_wake_rise) else $error("flag rise no wake");

endmodule

`default_nettype wire

/* rtl/tpic_pkg.sv */
// Package for the timer and pin interrupt controller.
// Assumes an APB master on pclk and a core sequencer that owns the stack.
package tpic_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_ICR      = 8'h00;
    localparam logic [7:0] OFF_TCTL     = 8'h04;
    localparam logic [7:0] OFF_PRELOAD  = 8'h08;

    // Interrupt control register fields
    localparam int ICR_GIE  = 0;
    localparam int ICR_PIE  = 1;
    localparam int ICR_TIE  = 2;
    localparam int ICR_PIF  = 4;
    localparam int ICR_TIF  = 5;
    localparam logic [7:0] ICR_IMPL_MASK = 8'h37;
    localparam logic [7:0] ICR_RESET     = 8'h00;

    // Timer control register fields
    localparam int TC_PSC_LSB  = 0;
    localparam int TC_EDGE     = 3;
    localparam int TC_RUN      = 4;
    localparam int TC_MODE_LSB = 6;
    localparam logic [7:0] TC_RESET      = 8'h00;
    localparam logic [7:0] PRELOAD_RESET = 8'h00;

    // Timer operating modes
    localparam logic [1:0] MODE_EVENT = 2'b01;
    localparam logic [1:0] MODE_TIMER = 2'b10;
    localparam logic [1:0] MODE_PULSE = 2'b11;

    // Vectors and entry delays in instruction cycles
    localparam logic [7:0] VEC_PIN   = 8'h04;
    localparam logic [7:0] VEC_TMR   = 8'h08;
    localparam logic [1:0] DLY_RUN   = 2'd2;
    localparam logic [1:0] DLY_WAKE  = 2'd3;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tpic_apb_req_t;

    // Service state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_ENTER
    } tpic_state_t;

endpackage

/* dv/tpic_core_model.sv */
// Core sequencer model: instruction boundaries, program counter, stack depth.
// Assumes the controller pulses irq_take and pop_req for one pclk each.
`timescale 1ns/1ps
`default_nettype none
module tpic_core_model #(
    parameter int PC_W = 11
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic [3:0]      period,
    input  wire logic [2:0]      depth_limit,
    input  wire logic            irq_take,
    input  wire logic [PC_W-1:0] irq_vector,
    input  wire logic            pop_req,
    output logic                 instr_end,
    output logic                 stack_full,
    output logic [PC_W-1:0]      next_pc
);
    logic [3:0] tick_reg;
    logic [2:0] depth_reg;
    logic       tick_wrap;

    // Stack reports full once the depth reaches the bench's limit
    assign stack_full = (depth_reg >= depth_limit);
    assign tick_wrap  = ((tick_reg + 4'h1) >= period);

    // Boundary pulse every period cycles; branch and stack bookkeeping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_reg  <= 4'h0;
            instr_end <= 1'b0;
            next_pc   <= '0;
            depth_reg <= 3'h0;
        end
        else
        begin
            tick_reg  <= tick_wrap ? 4'h0 : tick_reg + 4'h1;
            instr_end <= tick_wrap;
            if (irq_take)
                next_pc <= irq_vector;
            else if (instr_end)
                next_pc <= next_pc + PC_W'(1);
            if (irq_take && !pop_req)
                depth_reg <= depth_reg + 3'h1;
            else if (pop_req && !irq_take && depth_reg != 3'h0)
                depth_reg <= depth_reg - 3'h1;
        end
    end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the interrupt controller and its counter.
// Assumes the core model is compiled first; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tpic_pkg::*;
    logic          pclk;
    logic          presetn;
    tpic_apb_req_t req;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          instr_end;
    logic          ret_exec;
    logic          return_from_irq_instr_exec;
    logic          stack_full;
    logic          sleeping;
    logic [10:0]   next_pc;
    logic          pin_irq_in;
    logic          tmr_pin_in;
    logic          irq_take;
    logic [10:0]   irq_vector;
    logic [10:0]   push_pc;
    logic          pop_req;
    logic          wake;
    logic [2:0]    depth_limit;
    logic [31:0]   q;
    logic [31:0]   q1;
    logic [31:0]   seed;
    logic          err_seen;
    logic [10:0]   pc_seen;
    int            errors;
    int            total_checks;
    int            ie_cnt = 0;
    int            wk_cnt = 0;
    int            ie_take = 0;
    int            mark;
    int            i;

    tpic_ctrl #(.PC_W(11)) dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_end(instr_end),
        .ret_exec(ret_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec), .stack_full(stack_full),
        .sleeping(sleeping), .next_pc(next_pc), .pin_irq_in(pin_irq_in),
        .tmr_pin_in(tmr_pin_in), .irq_take(irq_take), .irq_vector(irq_vector),
        .push_pc(push_pc), .pop_req(pop_req), .wake(wake));
    tpic_core_model #(.PC_W(11)) core_u (.pclk(pclk), .presetn(presetn), .period(4'h4),
        .depth_limit(depth_limit), .irq_take(irq_take), .irq_vector(irq_vector),
        .pop_req(pop_req), .instr_end(instr_end), .stack_full(stack_full),
        .next_pc(next_pc));

    // Clock of 8 ns
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Counts of boundary and wake pulses
    always @(posedge pclk)
    begin
        if (instr_end === 1'b1) ie_cnt <= ie_cnt + 1;
        if (wake === 1'b1) wk_cnt <= wk_cnt + 1;
        if (irq_take === 1'b1) ie_take <= ie_cnt;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Readback of the interrupt control register: unimplemented bits are zero
    function automatic logic [31:0] icr_exp(input logic [31:0] w);
        return {24'h0, w[7:0] & ICR_IMPL_MASK};
    endfunction

    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; result in q and err_seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        q = prdata;
        err_seen = pslverr;
        req <= '0;
        if (n >= 40)
        begin
            errors++;
            complete_run();
        end
    endtask

    // Wait for irq_take (k=0) or wake (k=1); exp tells whether it must come
    task automatic wait_ev(input int k, input int lim, input logic exp);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < lim && hit !== 1'b1; n++)
        begin
            pc_seen = next_pc;
            @(posedge pclk);
            #1;
            hit = (k == 0) ? irq_take : wake;
        end
        chk({31'h0, hit}, {31'h0, exp});
        if (exp && hit !== 1'b1) complete_run();
    endtask

    task automatic ret_pulse(input logic r);
        @(posedge pclk);
        if (r) return_from_irq_instr_exec <= 1'b1;
        else ret_exec <= 1'b1;
        @(posedge pclk);
        return_from_irq_instr_exec <= 1'b0;
        ret_exec <= 1'b0;
        #1;
        chk({31'h0, pop_req}, 32'h1);
    endtask

    task automatic pin_pulse();
        @(posedge pclk);
        pin_irq_in <= 1'b1;
        repeat (6) @(posedge pclk);
        pin_irq_in <= 1'b0;
    endtask

    task automatic tmr_edges(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            tmr_pin_in <= 1'b1;
            repeat (4) @(posedge pclk);
            tmr_pin_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask

    task automatic take_chk(input logic [31:0] vec, input logic [31:0] icr);
        wait_ev(0, 80, 1'b1);
        chk({21'h0, irq_vector}, vec);
        chk({21'h0, push_pc}, {21'h0, pc_seen});
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, icr);
    endtask

    initial
    begin
        presetn = 1'b0;
        req = '0;
        ret_exec = 1'b0;
        return_from_irq_instr_exec = 1'b0;
        sleeping = 1'b0;
        pin_irq_in = 1'b0;
        tmr_pin_in = 1'b0;
        depth_limit = 3'h7;
        seed = 32'd47;
        errors = 0;
        total_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, {24'h0, ICR_RESET});
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        for (i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            q1 = (i == 0) ? 32'hfe : seed & 32'hfe;
            apb(1'b1, OFF_ICR, q1);
            apb(1'b0, OFF_ICR, 32'h0);
            chk(q, icr_exp(q1));
        end
        $display("test registers done");
        // Pin request held while global enable is off, then taken on time
        apb(1'b1, OFF_ICR, 32'h02);
        pin_pulse();
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, 32'h12);
        wait_ev(0, 30, 1'b0);
        apb(1'b1, OFF_ICR, 32'h13);
        #1 mark = ie_cnt;
        take_chk(32'h04, 32'h02);
        chk(32'(ie_take - mark), 32'h3);
        ret_pulse(1'b0);
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, 32'h02);
        // Both pending: pin first, return-from-interrupt lets timer in
        apb(1'b1, OFF_ICR, 32'h36);
        apb(1'b1, OFF_ICR, 32'h37);
        take_chk(32'h04, 32'h26);
        ret_pulse(1'b1);
        take_chk(32'h08, 32'h06);
        ret_pulse(1'b1);
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, 32'h07);
        // Nesting: the service routine sets the global enable again
        apb(1'b1, OFF_ICR, 32'h36);
        apb(1'b1, OFF_ICR, 32'h37);
        take_chk(32'h04, 32'h26);
        apb(1'b1, OFF_ICR, 32'h27);
        take_chk(32'h08, 32'h06);
        ret_pulse(1'b1);
        ret_pulse(1'b1);
        $display("test service done");
        // Full stack holds the request
        depth_limit <= 3'h0;
        apb(1'b1, OFF_ICR, 32'h13);
        wait_ev(0, 40, 1'b0);
        apb(1'b0, OFF_ICR, 32'h0);
        chk(q, 32'h13);
        depth_limit <= 3'h7;
        take_chk(32'h04, 32'h02);
        apb(1'b1, OFF_ICR, 32'h00);
        ret_pulse(1'b0);
        $display("test stack done");
        // Timer overflow, then stop with the run bit
        apb(1'b1, OFF_PRELOAD, 32'hfe);
        apb(1'b1, OFF_ICR, 32'h05);
        apb(1'b1, OFF_TCTL, 32'h90);
        take_chk(32'h08, 32'h24);
        apb(1'b1, OFF_TCTL, 32'h80);
        apb(1'b0, OFF_PRELOAD, 32'h0);
        q1 = q;
        repeat (5) apb(1'b0, OFF_PRELOAD, 32'h0);
        chk(q, q1);
        apb(1'b1, OFF_ICR, 32'h00);
        ret_pulse(1'b0);
        $display("test timer done");
        // Pulse width: the pin returning low stops the count and clears run
        apb(1'b1, OFF_PRELOAD, 32'h00);
        apb(1'b1, OFF_TCTL, 32'hd8);
        tmr_edges(1);
        apb(1'b0, OFF_TCTL, 32'h0);
        chk(q, 32'hc8);
        apb(1'b0, OFF_PRELOAD, 32'h0);
        chk(32'(q > 0 && q < 5), 32'h1);
        $display("test pulse done");
        // Event counting while asleep wakes; a preset flag suppresses it
        apb(1'b1, OFF_PRELOAD, 32'hfd);
        sleeping <= 1'b1;
        apb(1'b1, OFF_TCTL, 32'h50);
        mark = wk_cnt;
        tmr_edges(4);
        chk(32'(wk_cnt > mark), 32'h1);
        apb(1'b1, OFF_ICR, 32'h20);
        repeat (2) @(posedge pclk);
        mark = wk_cnt;
        tmr_edges(4);
        chk(32'(wk_cnt - mark), 32'h0);
        apb(1'b1, OFF_TCTL, 32'h00);
        apb(1'b1, OFF_ICR, 32'h00);
        repeat (2) @(posedge pclk);
        mark = wk_cnt;
        pin_pulse();
        repeat (3) @(posedge pclk);
        chk(32'(wk_cnt > mark), 32'h1);
        sleeping <= 1'b0;
        apb(1'b1, OFF_ICR, 32'h13);
        #1 mark = ie_cnt;
        take_chk(32'h04, 32'h02);
        chk(32'(ie_take - mark), 32'h4);
        $display("test sleep done");
        complete_run();
    end
endmodule
`default_nettype wire
